// file: shared/ldct_pkg.sv
package ldct_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] LDCT_CTRL_ADDR        = 8'h88;
  localparam logic [7:0] LDCT_MODE_ADDR        = 8'h89;
  localparam logic [7:0] LDCT_FIRST_LOW_ADDR   = 8'h8a;
  localparam logic [7:0] LDCT_SECOND_LOW_ADDR  = 8'h8b;
  localparam logic [7:0] LDCT_FIRST_HIGH_ADDR  = 8'h8c;
  localparam logic [7:0] LDCT_SECOND_HIGH_ADDR = 8'h8d;
  localparam logic [7:0] LDCT_CLKSEL_ADDR      = 8'h8e;
  localparam logic [7:0] LDCT_GATECFG_ADDR     = 8'h90;
  localparam logic [7:0] LDCT_IRQEN_ADDR       = 8'h91;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LDCT_CTRL_SECOND_FLAG = 7;
  localparam int LDCT_CTRL_SECOND_RUN  = 6;
  localparam int LDCT_CTRL_FIRST_FLAG  = 5;
  localparam int LDCT_CTRL_FIRST_RUN   = 4;
  localparam int LDCT_MODE_SECOND_GATE = 7;
  localparam int LDCT_MODE_SECOND_CSEL = 6;
  localparam int LDCT_MODE_SECOND_LSB  = 4;
  localparam int LDCT_MODE_FIRST_GATE  = 3;
  localparam int LDCT_MODE_FIRST_CSEL  = 2;
  localparam int LDCT_MODE_FIRST_LSB   = 0;
  localparam int LDCT_CLK_SECOND_SEL   = 3;
  localparam int LDCT_CLK_FIRST_SEL    = 2;
  localparam int LDCT_CLK_PRESC_LSB    = 0;
  localparam int LDCT_GCFG_FIRST_POL   = 0;
  localparam int LDCT_GCFG_SECOND_POL  = 1;
  localparam int LDCT_IRQ_FIRST_EN     = 0;
  localparam int LDCT_IRQ_SECOND_EN    = 1;

  // ----------------------------------------------------------------
  // Reset values and divider counts
  // ----------------------------------------------------------------
  localparam logic [7:0] LDCT_REG_RESET = 8'h00;
  localparam logic [5:0] LDCT_DIV_LAST [0:2] = '{6'd11, 6'd3, 6'd47};
  localparam logic [2:0] LDCT_EXT_DIV_LAST = 3'd7;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LDCT_MODE_13BIT  = 2'b00,
    LDCT_MODE_16BIT  = 2'b01,
    LDCT_MODE_RELOAD = 2'b10,
    LDCT_MODE_SPLIT  = 2'b11
  } ldct_mode_e;

  typedef enum logic [1:0] {
    LDCT_PRESC_DIV12  = 2'b00,
    LDCT_PRESC_DIV4   = 2'b01,
    LDCT_PRESC_DIV48  = 2'b10,
    LDCT_PRESC_EXT8   = 2'b11
  } ldct_presc_e;

endpackage

// file: verilog/ldct_timers.sv
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Each timer picks system clock or one of four prescaled clocks.
// R2 - Counter function counts each falling edge on the count pin.
// R3 - Count pin levels last two clocks; up to a quarter clock rate.
// R4 - Each count is sixteen bits, read and written as two bytes.
// R5 - Mode, source, gating and run are set per timer independently.
// R6 - Mode 0 is 13 bits: high byte plus low five bits.
// R7 - 13-bit wrap sets the overflow flag; interrupt if enabled.
// R8 - Pin when counter select set, else system or prescaled clock.
// R9 - Counts only when run and gate off or gate input active.
// R10 - Setting run keeps the count; counting resumes from it.
// R11 - Software loads the start value before setting run.
// R12 - Second timer gates on the second input with its own polarity.
// R13 - Mode 1 counts all sixteen bits, same enabling as mode 0.
// R14 - Mode 2 low byte counts, reloads from high byte, sets flag.
// R15 - Software sets the low byte before enabling mode 2.
// R16 - Mode 3 low byte uses first timer controls, pin or clock.
// R17 - Mode 3 high byte counts clocks under second run, second flag.
// R18 - Second timer in mode 3 stops and holds.
// R19 - Split mode: second timer no pin, no flag, overflow still out.
// R20 - Split mode: second timer runs in modes 0-2 regardless of run.
// R21 - Overflow flag raises interrupt only when its enable is set.
// R22 - Prescale codes: divide 12, 4, 48, or external divided by 8.
// R23 - Flags clear by software write or on interrupt acknowledge.
// R24 - Mode field codes 0..3 are 13-bit, 16-bit, reload, split.
// R25 - Count pins synchronised; falling edge gives one-cycle enable.
module ldct_timers
  import ldct_pkg::*;
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // External pins
  input  wire logic       i_first_count_pin,
  input  wire logic       i_second_count_pin,
  input  wire logic       i_first_gate_input,
  input  wire logic       i_second_gate_input,
  input  wire logic       i_ext_clk,
  // Interrupt side
  input  wire logic       i_first_irq_ack,
  input  wire logic       i_second_irq_ack,
  output logic            o_first_irq,
  output logic            o_second_irq,
  output logic            o_second_overflow
);

  // ----------------------------------------------------------------
  // Step function for one timer
  // ----------------------------------------------------------------
  function automatic logic [16:0] ldct_step(input logic [1:0] mode,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0]  c8;
    c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    c16 = {1'b0, hi, lo} + 17'h00001;
    c8  = {1'b0, lo} + 9'h001;
    case (mode)
      LDCT_MODE_13BIT:  ldct_step = {c13[13], c13[12:5], lo[7:5],
                                     c13[4:0]};               // [R6]
      LDCT_MODE_16BIT:  ldct_step = c16;                      // [R13]
      LDCT_MODE_RELOAD: ldct_step = {c8[8], hi,
                                     c8[8] ? hi : c8[7:0]};   // [R14]
      default:          ldct_step = {c8[8], hi, c8[7:0]};     // [R16]
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  mode_r;
  logic [7:0]  clksel_r;
  logic [1:0]  gatecfg_r;
  logic [1:0]  irqen_r;
  logic        first_run_r;
  logic        second_run_r;
  logic        first_flag_r;
  logic        second_flag_r;
  logic [7:0]  first_lo_r;
  logic [7:0]  first_hi_r;
  logic [7:0]  second_lo_r;
  logic [7:0]  second_hi_r;

  logic wr_ctrl;
  logic wr_f_lo;
  logic wr_f_hi;
  logic wr_s_lo;
  logic wr_s_hi;
  assign wr_ctrl = i_wr && (i_addr == LDCT_CTRL_ADDR);
  assign wr_f_lo = i_wr && (i_addr == LDCT_FIRST_LOW_ADDR);
  assign wr_f_hi = i_wr && (i_addr == LDCT_FIRST_HIGH_ADDR);
  assign wr_s_lo = i_wr && (i_addr == LDCT_SECOND_LOW_ADDR);
  assign wr_s_hi = i_wr && (i_addr == LDCT_SECOND_HIGH_ADDR);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mode_r    <= LDCT_REG_RESET;
      clksel_r  <= LDCT_REG_RESET;
      gatecfg_r <= LDCT_REG_RESET[1:0];
      irqen_r   <= LDCT_REG_RESET[1:0];
    end else if (i_wr) begin
      case (i_addr)
        LDCT_MODE_ADDR:    mode_r    <= i_wdata;              // [R5]
        LDCT_CLKSEL_ADDR:  clksel_r  <= {4'h0, i_wdata[3:0]};
        LDCT_GATECFG_ADDR: gatecfg_r <= i_wdata[1:0];
        LDCT_IRQEN_ADDR:   irqen_r   <= i_wdata[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [4:0] pin_in;
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [4:0] prev_r;
  logic       first_fall;
  logic       second_fall;
  logic       ext_rise;
  assign pin_in = {i_ext_clk, i_second_gate_input, i_first_gate_input,
                   i_second_count_pin, i_first_count_pin};

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      prev_r  <= 5'h00;
    end else begin
      sync1_r <= pin_in;                                      // [R25]
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign first_fall  = prev_r[0] & ~sync2_r[0];               // [R25]
  assign second_fall = prev_r[1] & ~sync2_r[1];               // [R3]
  assign ext_rise    = ~prev_r[4] & sync2_r[4];

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic [2:0] div_tick;
  logic [2:0] ext_cnt_r;
  logic       ext_tick;
  logic       presc_tick;
  ldct_presc_e presc;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_div
      logic [5:0] cnt_r;
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          cnt_r <= 6'h00;
        end else if (cnt_r == LDCT_DIV_LAST[g]) begin
          cnt_r <= 6'h00;
        end else begin
          cnt_r <= cnt_r + 6'h01;
        end
      end
      assign div_tick[g] = (cnt_r == LDCT_DIV_LAST[g]);
    end
  endgenerate

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ext_cnt_r <= 3'h0;
    end else if (ext_rise) begin
      ext_cnt_r <= ext_cnt_r + 3'h1;
    end
  end
  assign ext_tick = ext_rise && (ext_cnt_r == LDCT_EXT_DIV_LAST);

  assign presc = ldct_presc_e'(clksel_r[LDCT_CLK_PRESC_LSB +: 2]);
  always_comb begin
    case (presc)                                              // [R22]
      LDCT_PRESC_DIV12: presc_tick = div_tick[0];
      LDCT_PRESC_DIV4:  presc_tick = div_tick[1];
      LDCT_PRESC_DIV48: presc_tick = div_tick[2];
      LDCT_PRESC_EXT8:  presc_tick = ext_tick;
      default:          presc_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Count enables
  // ----------------------------------------------------------------
  ldct_mode_e first_mode;
  ldct_mode_e second_mode;
  logic first_clk;
  logic second_clk;
  logic split;
  logic first_run;
  logic second_run;
  logic first_inc;
  logic second_inc;
  logic hi_inc;
  assign first_mode  = ldct_mode_e'(mode_r[LDCT_MODE_FIRST_LSB +: 2]);
  assign second_mode = ldct_mode_e'(mode_r[LDCT_MODE_SECOND_LSB +: 2]);
  assign split = (first_mode == LDCT_MODE_SPLIT);             // [R24]

  assign first_clk  = clksel_r[LDCT_CLK_FIRST_SEL] | presc_tick;  // [R1]
  assign second_clk = clksel_r[LDCT_CLK_SECOND_SEL] | presc_tick;

  assign first_run = first_run_r &&
    (!mode_r[LDCT_MODE_FIRST_GATE] ||
     (sync2_r[2] == gatecfg_r[LDCT_GCFG_FIRST_POL]));         // [R9]
  assign second_run = (second_mode != LDCT_MODE_SPLIT) &&     // [R18]
    (split ||                                                 // [R20]
     (second_run_r &&
      (!mode_r[LDCT_MODE_SECOND_GATE] ||
       (sync2_r[3] == gatecfg_r[LDCT_GCFG_SECOND_POL]))));    // [R12]

  assign first_inc = first_run &&
    (mode_r[LDCT_MODE_FIRST_CSEL] ? first_fall : first_clk);  // [R8] [R2]
  assign second_inc = second_run &&
    ((mode_r[LDCT_MODE_SECOND_CSEL] && !split) ?
     second_fall : second_clk);                               // [R19]
  assign hi_inc = split && second_run_r && first_clk;         // [R17]

  // ----------------------------------------------------------------
  // Count registers
  // ----------------------------------------------------------------
  logic [16:0] first_step;
  logic [16:0] second_step;
  logic        first_ovf;
  logic        second_ovf;
  logic        hi_ovf;
  assign first_step  = ldct_step(first_mode, first_lo_r, first_hi_r);
  assign second_step = ldct_step(second_mode, second_lo_r, second_hi_r);
  assign first_ovf  = first_inc && first_step[16];            // [R7]
  assign second_ovf = second_inc && second_step[16];
  assign hi_ovf     = hi_inc && (first_hi_r == 8'hff);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      first_lo_r <= LDCT_REG_RESET;
      first_hi_r <= LDCT_REG_RESET;
    end else begin
      if (wr_f_lo) begin
        first_lo_r <= i_wdata;                                // [R4]
      end else if (first_inc) begin
        first_lo_r <= first_step[7:0];                        // [R10]
      end
      if (wr_f_hi) begin
        first_hi_r <= i_wdata;
      end else if (split) begin
        if (hi_inc) begin
          first_hi_r <= first_hi_r + 8'h01;                   // [R17]
        end
      end else if (first_inc) begin
        first_hi_r <= first_step[15:8];
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      second_lo_r <= LDCT_REG_RESET;
      second_hi_r <= LDCT_REG_RESET;
    end else begin
      if (wr_s_lo) begin
        second_lo_r <= i_wdata;
      end else if (second_inc) begin
        second_lo_r <= second_step[7:0];                      // [R5]
      end
      if (wr_s_hi) begin
        second_hi_r <= i_wdata;
      end else if (second_inc) begin
        second_hi_r <= second_step[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register: run bits and overflow flags
  // ----------------------------------------------------------------
  logic first_set;
  logic second_set;
  assign first_set  = first_ovf;
  assign second_set = split ? hi_ovf : second_ovf;            // [R19]

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      first_run_r   <= 1'b0;
      second_run_r  <= 1'b0;
      first_flag_r  <= 1'b0;
      second_flag_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        first_run_r  <= i_wdata[LDCT_CTRL_FIRST_RUN];
        second_run_r <= i_wdata[LDCT_CTRL_SECOND_RUN];
      end
      first_flag_r <= first_set |                             // [R23]
        (~i_first_irq_ack &
         (wr_ctrl ? i_wdata[LDCT_CTRL_FIRST_FLAG] : first_flag_r));
      second_flag_r <= second_set |
        (~i_second_irq_ack &
         (wr_ctrl ? i_wdata[LDCT_CTRL_SECOND_FLAG] : second_flag_r));
    end
  end

  assign o_first_irq  = first_flag_r & irqen_r[LDCT_IRQ_FIRST_EN];  // [R21]
  assign o_second_irq = second_flag_r & irqen_r[LDCT_IRQ_SECOND_EN];

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_second_overflow <= 1'b0;
    end else begin
      o_second_overflow <= second_ovf;                        // [R19]
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] rd_nxt;
  always_comb begin
    case (i_addr)
      LDCT_CTRL_ADDR:        rd_nxt = {second_flag_r, second_run_r,
                                       first_flag_r, first_run_r, 4'h0};
      LDCT_MODE_ADDR:        rd_nxt = mode_r;
      LDCT_FIRST_LOW_ADDR:   rd_nxt = first_lo_r;
      LDCT_SECOND_LOW_ADDR:  rd_nxt = second_lo_r;
      LDCT_FIRST_HIGH_ADDR:  rd_nxt = first_hi_r;
      LDCT_SECOND_HIGH_ADDR: rd_nxt = second_hi_r;
      LDCT_CLKSEL_ADDR:      rd_nxt = clksel_r;
      LDCT_GATECFG_ADDR:     rd_nxt = {6'h00, gatecfg_r};
      LDCT_IRQEN_ADDR:       rd_nxt = {6'h00, irqen_r};
      default:               rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_nxt : 8'h00;                       // [R4]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  property p_flag_set;
    first_ovf |=> first_flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set)                    // [R7]
    else $error("first overflow did not set its flag");

  property p_hold_stopped;
    !first_run_r && !wr_f_lo && !wr_f_hi && !split |=>
      {first_hi_r, first_lo_r} == $past({first_hi_r, first_lo_r});
  endproperty
  a_hold_stopped: assert property (p_hold_stopped)            // [R9]
    else $error("first count moved while not running");

  property p_reload;
    first_ovf && first_mode == LDCT_MODE_RELOAD && !wr_f_lo && !wr_f_hi
      |=> first_lo_r == $past(first_hi_r) &&
          first_hi_r == $past(first_hi_r);
  endproperty
  a_reload: assert property (p_reload)                        // [R14]
    else $error("reload value not taken from high byte");

  property p_second_split_stop;
    second_mode == LDCT_MODE_SPLIT && !wr_s_lo && !wr_s_hi |=>
      $stable(second_lo_r) && $stable(second_hi_r);
  endproperty
  a_second_split_stop: assert property (p_second_split_stop)  // [R18]
    else $error("second timer moved in mode 3");

  property p_pin_count;
    first_run && mode_r[LDCT_MODE_FIRST_CSEL] && first_fall &&
      first_mode == LDCT_MODE_16BIT && !wr_f_lo && !wr_f_hi |=>
      {first_hi_r, first_lo_r} == $past({first_hi_r, first_lo_r}) + 16'h1;
  endproperty
  a_pin_count: assert property (p_pin_count)                  // [R2]
    else $error("pin falling edge did not increment count");

  property p_div12;
    div_tick[0] |=> !div_tick[0] ##11 div_tick[0];
  endproperty
  a_div12: assert property (p_div12)                          // [R22]
    else $error("divide by 12 tick spacing wrong");

  property p_ack_clear;
    i_first_irq_ack && !first_ovf |=> !first_flag_r;
  endproperty
  a_ack_clear: assert property (p_ack_clear)                  // [R23]
    else $error("acknowledge did not clear first flag");

  property p_hi_overflow;
    hi_ovf |=> second_flag_r && first_hi_r == 8'h00;
  endproperty
  a_hi_overflow: assert property (p_hi_overflow)              // [R17]
    else $error("split high byte overflow missed second flag");

  property p_split_no_flag;
    split && second_ovf && !hi_ovf && !wr_ctrl && !i_second_irq_ack
      |=> o_second_overflow && second_flag_r == $past(second_flag_r);
  endproperty
  a_split_no_flag: assert property (p_split_no_flag)          // [R19]
    else $error("second overflow in split mode misbehaved");

  property p_irq_gate;
    first_ovf && irqen_r[LDCT_IRQ_FIRST_EN] &&
      !(i_wr && i_addr == LDCT_IRQEN_ADDR) |=> o_first_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)                    // [R21]
    else $error("first interrupt missing after enabled overflow");

  c_mode0_ovf: cover property (first_ovf &&
                               first_mode == LDCT_MODE_13BIT);
  c_reload:    cover property (first_ovf &&
                               first_mode == LDCT_MODE_RELOAD);
  c_split_hi:  cover property (hi_ovf);
  c_pin_inc:   cover property (first_inc &&
                               mode_r[LDCT_MODE_FIRST_CSEL]);

endmodule

// file: sim/ldct_pin_model.sv
`timescale 1ns/1ps
module ldct_pin_model (
  // Clock
  input  wire logic i_mclk,
  // Pins toward the timers
  output logic      o_first_count_pin,
  output logic      o_second_count_pin,
  output logic      o_first_gate_input,
  output logic      o_second_gate_input,
  output logic      o_ext_clk
);
  logic [1:0] ext_cnt_r;

  initial begin
    o_first_count_pin   = 1'b1;
    o_second_count_pin  = 1'b1;
    o_first_gate_input  = 1'b0;
    o_second_gate_input = 1'b0;
    o_ext_clk           = 1'b0;
    ext_cnt_r           = 2'd0;
  end

  // --------------------------------------------------------------
  // Free external clock, six system cycles a period
  // --------------------------------------------------------------
  always @(posedge i_mclk) begin
    ext_cnt_r <= (ext_cnt_r == 2'd2) ? 2'd0 : ext_cnt_r + 2'd1;
    if (ext_cnt_r == 2'd2) begin
      o_ext_clk <= ~o_ext_clk;
    end
  end

  // --------------------------------------------------------------
  // Count pin events, each level held at least two cycles
  // --------------------------------------------------------------
  task automatic falls(input logic which, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      repeat (hold) @(posedge i_mclk);
      if (which) o_second_count_pin <= 1'b0;
      else o_first_count_pin <= 1'b0;
      repeat (hold) @(posedge i_mclk);
      if (which) o_second_count_pin <= 1'b1;
      else o_first_count_pin <= 1'b1;
    end
  endtask

  task automatic gate(input logic which, input logic lvl);
    @(posedge i_mclk);
    if (which) o_second_gate_input <= lvl;
    else o_first_gate_input <= lvl;
  endtask
endmodule

// file: sim/test_ldct_timers.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  error_cnt++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_ldct_timers
  import ldct_pkg::*;
;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       first_ack = 1'b0;
  logic       second_ack = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic       irq1, irq2, ovf2;
  wire        pin1, pin2, second_gate_bit, gate2, ext_clk;
  int         error_cnt = 0;
  int         n_compared = 0;
  int         seed = 85;
  int         ovf_seen = 0;
  logic [7:0] reg_list [10] = '{LDCT_CTRL_ADDR, LDCT_MODE_ADDR,
    LDCT_FIRST_LOW_ADDR, LDCT_SECOND_LOW_ADDR, LDCT_FIRST_HIGH_ADDR,
    LDCT_SECOND_HIGH_ADDR, LDCT_CLKSEL_ADDR, LDCT_GATECFG_ADDR,
    LDCT_IRQEN_ADDR, 8'h8f};
  logic [7:0] clk_code [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04};
  int         div_tab [5] = '{12, 4, 48, 48, 1};

  always #5 mclk = ~mclk;
  always @(posedge mclk) if (ovf2 === 1'b1) ovf_seen++;

  ldct_timers i_ldct_timers (.i_mclk(mclk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_first_count_pin(pin1), .i_second_count_pin(pin2),
    .i_first_gate_input(second_gate_bit), .i_second_gate_input(gate2),
    .i_ext_clk(ext_clk), .i_first_irq_ack(first_ack),
    .i_second_irq_ack(second_ack), .o_first_irq(irq1),
    .o_second_irq(irq2), .o_second_overflow(ovf2));
  ldct_pin_model i_ldct_pin_model (.i_mclk(mclk), .o_first_count_pin(pin1),
    .o_second_count_pin(pin2), .o_first_gate_input(second_gate_bit),
    .o_second_gate_input(gate2), .o_ext_clk(ext_clk));

  // --------------------------------------------------------------
  // Bus tasks and expectations
  // --------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    `CHK(nm, e, d)
  endtask

  task automatic print_verdict;
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [16:0] step_exp(input logic [1:0] m,
                                           input logic [15:0] v,
                                           input int n);
    logic        ov;
    logic [12:0] c;
    ov = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (m == 2'd0) begin
        c = {v[15:8], v[4:0]} + 13'd1;
        ov |= (c == 13'd0);
        v = {c[12:5], v[7:5], c[4:0]};
      end else if (m == 2'd1) begin
        ov |= (v == 16'hffff);
        v = v + 16'd1;
      end else begin
        ov |= (v[7:0] == 8'hff);
        v[7:0] = (v[7:0] == 8'hff) ? v[15:8] : v[7:0] + 8'd1;
      end
    end
    return {ov, v};
  endfunction

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    logic [7:0]  lo, hi, en, mv;
    logic        ok;
    logic [16:0] e;
    logic [1:0]  m;
    int          n;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    for (int j = 0; j < 10; j++) rd_chk("reset", reg_list[j], 8'h00);
    for (int t = 0; t < 2; t++) begin
      for (int mi = 0; mi < 3; mi++) begin
        for (int k = 0; k < 2; k++) begin
          m = 2'(mi);
          lo = k ? 8'($random(seed)) : 8'hfd;
          hi = k ? 8'($random(seed)) : ((m == 2'd2) ? 8'h5a : 8'hff);
          n = k ? 1 + ($random(seed) & 3) : 3;
          en = k ? 8'h00 : (t ? 8'h02 : 8'h01);
          mv = 8'h04 | {6'd0, m};
          wr_reg(LDCT_MODE_ADDR, t ? {mv[3:0], 4'h0} : mv);
          wr_reg(LDCT_FIRST_LOW_ADDR + 8'(t), lo);
          wr_reg(LDCT_FIRST_HIGH_ADDR + 8'(t), hi);
          wr_reg(LDCT_IRQEN_ADDR, en);
          wr_reg(LDCT_CTRL_ADDR, t ? 8'h40 : 8'h10);
          i_ldct_pin_model.falls(t[0], n, 2 + k * 3);
          repeat (6) @(posedge mclk);
          e = step_exp(m, {hi, lo}, n);
          `CHK("irq", e[16] & (|en), t ? irq2 : irq1)
          rd_chk("flag", LDCT_CTRL_ADDR, t ? {e[16], 7'h40} :
                 {2'b00, e[16], 5'h10});
          @(posedge mclk);
          first_ack <= ~t[0];
          second_ack <= t[0];
          @(posedge mclk);
          first_ack <= 1'b0;
          second_ack <= 1'b0;
          rd_chk("ack", LDCT_CTRL_ADDR, t ? 8'h40 : 8'h10);
          wr_reg(LDCT_CTRL_ADDR, 8'h00);
          rd_chk("low", LDCT_FIRST_LOW_ADDR + 8'(t), e[7:0]);
          rd_chk("high", LDCT_FIRST_HIGH_ADDR + 8'(t), e[15:8]);
        end
      end
    end
    wr_reg(LDCT_MODE_ADDR, 8'hd0);
    wr_reg(LDCT_GATECFG_ADDR, 8'h02);
    wr_reg(LDCT_SECOND_LOW_ADDR, 8'h00);
    wr_reg(LDCT_CTRL_ADDR, 8'h40);
    i_ldct_pin_model.falls(1'b1, 3, 2);
    i_ldct_pin_model.gate(1'b1, 1'b1);
    repeat (4) @(posedge mclk);
    i_ldct_pin_model.falls(1'b1, 5, 2);
    repeat (6) @(posedge mclk);
    rd_chk("gated", LDCT_SECOND_LOW_ADDR, 8'h05);
    wr_reg(LDCT_CTRL_ADDR, 8'h00);
    for (int j = 0; j < 5; j++) begin
      wr_reg(LDCT_MODE_ADDR, 8'h01);
      wr_reg(LDCT_CLKSEL_ADDR, clk_code[j]);
      wr_reg(LDCT_FIRST_LOW_ADDR, 8'h00);
      wr_reg(LDCT_FIRST_HIGH_ADDR, 8'h00);
      wr_reg(LDCT_CTRL_ADDR, 8'h10);
      repeat (477) @(posedge mclk);
      wr_reg(LDCT_CTRL_ADDR, 8'h00);
      rd_reg(LDCT_FIRST_LOW_ADDR, lo);
      rd_reg(LDCT_FIRST_HIGH_ADDR, hi);
      n = {hi, lo};
      ok = (n >= 480 / div_tab[j] - 2) && (n <= 480 / div_tab[j] + 2);
      `CHK("presc", 1'b1, ok)
    end
    wr_reg(LDCT_MODE_ADDR, 8'h37);
    wr_reg(LDCT_CLKSEL_ADDR, 8'h04);
    wr_reg(LDCT_FIRST_LOW_ADDR, 8'hfe);
    wr_reg(LDCT_FIRST_HIGH_ADDR, 8'hf8);
    wr_reg(LDCT_SECOND_LOW_ADDR, 8'h55);
    wr_reg(LDCT_SECOND_HIGH_ADDR, 8'h66);
    wr_reg(LDCT_IRQEN_ADDR, 8'h02);
    wr_reg(LDCT_CTRL_ADDR, 8'h50);
    i_ldct_pin_model.falls(1'b0, 2, 2);
    repeat (6) @(posedge mclk);
    `CHK("split_irq", 1'b1, irq2)
    rd_chk("split_flags", LDCT_CTRL_ADDR, 8'hf0);
    wr_reg(LDCT_CTRL_ADDR, 8'h00);
    rd_chk("split_low", LDCT_FIRST_LOW_ADDR, 8'h00);
    rd_chk("held_low", LDCT_SECOND_LOW_ADDR, 8'h55);
    rd_chk("held_high", LDCT_SECOND_HIGH_ADDR, 8'h66);
    ovf_seen = 0;
    wr_reg(LDCT_MODE_ADDR, 8'h13);
    wr_reg(LDCT_CLKSEL_ADDR, 8'h08);
    wr_reg(LDCT_SECOND_LOW_ADDR, 8'hf0);
    wr_reg(LDCT_SECOND_HIGH_ADDR, 8'hff);
    repeat (40) @(posedge mclk);
    wr_reg(LDCT_MODE_ADDR, 8'h33);
    `CHK("ovf_pulses", 1, ovf_seen)
    rd_chk("no_flag", LDCT_CTRL_ADDR, 8'h00);
    print_verdict();
  end
endmodule
